// ### hdl/imu_sensor_config_regs.sv
//
// Contract
// - Pin mode bit, 0 pulsed, 1 latched; bit 5 pin b, bit 2 pin a.
// - Pin drive bit, 0 open drain, 1 push-pull; bit 4 b, bit 1 a.
// - Pin polarity bit, 0 active low, 1 active high; bit 3 b, bit 0 a.
// - Temperature is a 16-bit word over high and low byte registers.
// - Packed 8-bit temperature is the upper byte, lower byte treated as zero.
// - Axis samples are 16-bit, upper byte at lower address.
// - Frame-sync delta held until the host reads the sync tag.
// - Fall duration 16-bit, low byte at lower address.
// - Power bit 7 picks low-power clock; changeable while running.
// - Idle bit keeps RC oscillator on; otherwise both sensors off means off state.
// - Gyro mode 00 off, 01 standby, 10 reserved, 11 low noise.
// - Accel mode 00/01 off, 10 low power, 11 low noise.
// - Gyro full scale at bits 6:5, codes 0 to 3.
// - Gyro rate codes 0101 to 1100 valid, others reserved.
// - Accel full scale at bits 6:5, codes 0 to 3.
// - Accel rate codes 0101 to 1111, with mode limits at both ends.
// - Temperature filter 000 bypass, 111 same as 110.
// - Gyro filter at bits 2:0, 000 bypass.
// - Averaging at bits 6:4, 101 and up is 64x; frozen in low power.
// - Accel filter uses the gyro table, 000 bypass.
`timescale 1ns/100ps
module imu_sensor_config_regs #(
  parameter int PULSE_CYCLES = imu_cfg_pkg::IRQ_PULSE_CYCLES
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic sample_valid_in,
  input wire imu_cfg_pkg::sample_t sample_in,
  input wire logic frame_sync_input_in,
  input wire logic sync_tag_read_in,
  input wire logic fall_valid_in,
  input wire logic [15:0] fall_duration_count_in,
  input wire logic [1:0] irq_event_in,
  input wire logic [1:0] irq_clear_in,
  output logic irq_out_a_out,
  output logic irq_out_a_oe_n_out,
  output logic irq_out_b_out,
  output logic irq_out_b_oe_n_out,
  output imu_cfg_pkg::cfg_t cfg_out,
  output logic [7:0] temp_packet_byte_out
);
  import imu_cfg_pkg::*;

  if (PULSE_CYCLES < 1 || PULSE_CYCLES > 255) begin : g_bad_pulse
    $error("PULSE_CYCLES out of range");
  end

  logic [7:0] irq_cfg;
  logic [7:0] power;
  logic [7:0] rate_cfg;
  logic [7:0] accel_cfg;
  logic [7:0] temp_filt;
  logic [7:0] rate_filt;
  logic [7:0] accel_filt;
  logic [7:0] motion_cfg;
  sample_t samples;
  logic [15:0] fall_dur;
  logic [15:0] stamp;
  logic [15:0] delta_cnt;
  logic sync_prev;
  logic sync_armed;
  logic stamp_held;
  cfg_t next_cfg;
  logic [7:0] next_rdata;

  // Write decode
  wire wr_irq = reg_wr_in && reg_addr_in == ADDR_IRQ_CFG;
  wire wr_power = reg_wr_in && reg_addr_in == ADDR_POWER;
  wire wr_rate = reg_wr_in && reg_addr_in == ADDR_RATE_CFG;
  wire wr_accel = reg_wr_in && reg_addr_in == ADDR_ACCEL_CFG;
  wire wr_tfilt = reg_wr_in && reg_addr_in == ADDR_TEMP_FILT;
  wire wr_rfilt = reg_wr_in && reg_addr_in == ADDR_RATE_FILT;
  wire wr_afilt = reg_wr_in && reg_addr_in == ADDR_ACCEL_FILT;
  wire wr_motion = reg_wr_in && reg_addr_in == ADDR_MOTION;

  // Averaging is frozen while the accel runs in low power
  wire accel_low_power = cfg_out.accel == ACCEL_LOW_POWER;
  wire [2:0] avg_keep = accel_filt[AVG_LSB +: 3];
  wire [2:0] avg_new = accel_low_power ? avg_keep : reg_wdata_in[AVG_LSB +: 3];
  wire [7:0] accel_filt_wr = {reg_wdata_in[7], avg_new, reg_wdata_in[3:0]};

  // Frame-sync edge and capture on the output-rate sample
  wire sync_rise = frame_sync_input_in && !sync_prev;
  wire stamp_take = sample_valid_in && sync_armed && !stamp_held;
  wire [15:0] delta_inc = (delta_cnt == 16'hffff) ? delta_cnt : delta_cnt + 16'h0001;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_cfg <= RST_IRQ_CFG;
      power <= RST_POWER;
      rate_cfg <= RST_RATE_CFG;
      accel_cfg <= RST_ACCEL_CFG;
      temp_filt <= RST_TEMP_FILT;
      rate_filt <= RST_RATE_FILT;
      accel_filt <= RST_ACCEL_FILT;
      motion_cfg <= RST_MOTION;
    end else begin
      if (wr_irq) irq_cfg <= reg_wdata_in;
      if (wr_power) power <= reg_wdata_in;
      if (wr_rate) rate_cfg <= reg_wdata_in;
      if (wr_accel) accel_cfg <= reg_wdata_in;
      if (wr_tfilt) temp_filt <= reg_wdata_in;
      if (wr_rfilt) rate_filt <= reg_wdata_in;
      if (wr_afilt) accel_filt <= accel_filt_wr;
      if (wr_motion) motion_cfg <= reg_wdata_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      samples <= {7{RST_SAMPLE}};
      fall_dur <= '0;
    end else begin
      if (sample_valid_in) samples <= sample_in;
      if (fall_valid_in) fall_dur <= fall_duration_count_in;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sync_prev <= 1'b0;
      sync_armed <= 1'b0;
      stamp_held <= 1'b0;
      delta_cnt <= '0;
      stamp <= '0;
    end else begin
      sync_prev <= frame_sync_input_in;
      delta_cnt <= sync_rise ? 16'h0000 : delta_inc;
      sync_armed <= sync_rise || (sync_armed && !stamp_take);
      // A capture never coincides with a release: capture needs the stamp free
      stamp_held <= stamp_take || (stamp_held && !sync_tag_read_in);
      if (stamp_take) stamp <= delta_cnt;
    end
  end

  // Decode of the stored fields; reserved codes fall back to safe states
  always_comb begin
    next_cfg = '0;
    unique case (power[GYRO_MODE_LSB +: 2])
      GYRO_CODE_STANDBY: next_cfg.gyro = GYRO_STANDBY;
      MODE_CODE_LOW_NOISE: next_cfg.gyro = GYRO_LOW_NOISE;
      default: next_cfg.gyro = GYRO_OFF;
    endcase
    unique case (power[ACCEL_MODE_LSB +: 2])
      MODE_CODE_LOW_POWER: next_cfg.accel = ACCEL_LOW_POWER;
      MODE_CODE_LOW_NOISE: next_cfg.accel = ACCEL_LOW_NOISE;
      default: next_cfg.accel = ACCEL_OFF;
    endcase
    next_cfg.lowpower_clock_choice = power[CLK_SEL_BIT];
    next_cfg.rc_osc_on = power[IDLE_BIT] || next_cfg.gyro != GYRO_OFF || next_cfg.accel != ACCEL_OFF;
    next_cfg.chip_off = !next_cfg.rc_osc_on;
    next_cfg.rate_full_scale = rate_cfg[FS_LSB +: 2];
    next_cfg.rate_output_rate = rate_cfg[ODR_LSB +: 4];
    next_cfg.rate_odr_valid = rate_cfg[ODR_LSB +: 4] >= ODR_FIRST && rate_cfg[ODR_LSB +: 4] <= RATE_CODE_LAST;
    next_cfg.accel_full_scale = accel_cfg[FS_LSB +: 2];
    next_cfg.accel_output_rate = accel_cfg[ODR_LSB +: 4];
    next_cfg.accel_rate_valid = accel_cfg[ODR_LSB +: 4] >= ODR_FIRST && accel_cfg[ODR_LSB +: 4] <= ACCEL_CODE_LAST
      && !(next_cfg.accel == ACCEL_LOW_POWER && accel_cfg[ODR_LSB +: 4] <= ACCEL_NOISE_ONLY_LAST)
      && !(next_cfg.accel == ACCEL_LOW_NOISE && accel_cfg[ODR_LSB +: 4] >= ACCEL_POWER_ONLY_FIRST);
    next_cfg.temperature_filter_width = (temp_filt[TFILT_LSB +: 3] > TFILT_TOP) ? TFILT_TOP
      : temp_filt[TFILT_LSB +: 3];
    next_cfg.temp_lowpass_bypass = temp_filt[TFILT_LSB +: 3] == FILT_BYPASS;
    next_cfg.rate_filter_width = rate_filt[FILT_LSB +: 3];
    next_cfg.rate_lowpass_bypass = rate_filt[FILT_LSB +: 3] == FILT_BYPASS;
    next_cfg.accel_filter_width = accel_filt[FILT_LSB +: 3];
    next_cfg.accel_lowpass_bypass = accel_filt[FILT_LSB +: 3] == FILT_BYPASS;
    next_cfg.accel_averaging = (accel_filt[AVG_LSB +: 3] > AVG_TOP) ? AVG_TOP : accel_filt[AVG_LSB +: 3];
  end

  // Read decode
  always_comb begin
    unique case (reg_addr_in)
      ADDR_IRQ_CFG: next_rdata = irq_cfg;
      ADDR_TEMP_HI: next_rdata = samples.temp[15:8];
      ADDR_TEMP_LO: next_rdata = samples.temp[7:0];
      ADDR_AX_HI: next_rdata = samples.ax[15:8];
      ADDR_AX_LO: next_rdata = samples.ax[7:0];
      ADDR_AY_HI: next_rdata = samples.ay[15:8];
      ADDR_AY_LO: next_rdata = samples.ay[7:0];
      ADDR_AZ_HI: next_rdata = samples.az[15:8];
      ADDR_AZ_LO: next_rdata = samples.az[7:0];
      ADDR_GX_HI: next_rdata = samples.gx[15:8];
      ADDR_GX_LO: next_rdata = samples.gx[7:0];
      ADDR_GY_HI: next_rdata = samples.gy[15:8];
      ADDR_GY_LO: next_rdata = samples.gy[7:0];
      ADDR_GZ_HI: next_rdata = samples.gz[15:8];
      ADDR_GZ_LO: next_rdata = samples.gz[7:0];
      ADDR_STAMP_HI: next_rdata = stamp[15:8];
      ADDR_STAMP_LO: next_rdata = stamp[7:0];
      ADDR_FALL_LO: next_rdata = fall_dur[7:0];
      ADDR_FALL_HI: next_rdata = fall_dur[15:8];
      ADDR_POWER: next_rdata = power;
      ADDR_RATE_CFG: next_rdata = rate_cfg;
      ADDR_ACCEL_CFG: next_rdata = accel_cfg;
      ADDR_TEMP_FILT: next_rdata = temp_filt;
      ADDR_RATE_FILT: next_rdata = rate_filt;
      ADDR_ACCEL_FILT: next_rdata = accel_filt;
      ADDR_MOTION: next_rdata = motion_cfg;
      default: next_rdata = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= UNMAPPED_READ;
      cfg_out <= '0;
      temp_packet_byte_out <= RST_SAMPLE[15:8];
    end else begin
      if (reg_rd_in) reg_rdata_out <= next_rdata;
      cfg_out <= next_cfg;
      // Packet temperature keeps only the upper byte
      temp_packet_byte_out <= samples.temp[15:8];
    end
  end

  // Interrupt pins
  wire [1:0] pin_q;
  wire [1:0] oe_n_q;
  wire [1:0] active;
  for (genvar i = 0; i < 2; i++) begin : g_pin
    logic latched;
    logic [7:0] pulse_cnt;
    logic pin_r;
    logic oe_n_r;
    wire latch_mode = irq_cfg[LATCH_BIT[i]];
    wire push_pull = irq_cfg[DRIVE_BIT[i]];
    wire level_high = irq_cfg[LEVEL_BIT[i]];
    wire next_active = latch_mode ? latched : (pulse_cnt != 8'h00);
    wire pin_level = next_active ? level_high : !level_high;
    assign active[i] = next_active;
    assign pin_q[i] = pin_r;
    assign oe_n_q[i] = oe_n_r;
    always_ff @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
        latched <= 1'b0;
        pulse_cnt <= 8'h00;
        pin_r <= 1'b0;
        oe_n_r <= 1'b1;
      end else begin
        // Set wins over a clear in the same cycle
        latched <= irq_event_in[i] || (latched && !irq_clear_in[i]);
        if (irq_event_in[i]) begin
          pulse_cnt <= 8'(PULSE_CYCLES);
        end else if (pulse_cnt != 8'h00) begin
          pulse_cnt <= pulse_cnt - 8'h01;
        end
        // Open drain only pulls low and floats for a high level
        pin_r <= push_pull && pin_level;
        oe_n_r <= !push_pull && pin_level;
      end
    end
  end
  assign irq_out_a_out = pin_q[0];
  assign irq_out_a_oe_n_out = oe_n_q[0];
  assign irq_out_b_out = pin_q[1];
  assign irq_out_b_oe_n_out = oe_n_q[1];

  // Cycles since the last pin b event, saturating; bounds the pulse without a long repetition
  logic [8:0] since_evt_b;
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      since_evt_b <= 9'h1ff;
    end else if (irq_event_in[1]) begin
      since_evt_b <= 9'h000;
    end else if (since_evt_b != 9'h1ff) begin
      since_evt_b <= since_evt_b + 9'h001;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  a_latch_holds: assert property (irq_cfg[LATCH_BIT[0]] && irq_event_in[0] ##1 !irq_clear_in[0] [*3]
    |-> active[0]) else $error("Latched pin a dropped");
  a_pulse_ends: assert property (!irq_cfg[LATCH_BIT[1]] && since_evt_b >= 9'(PULSE_CYCLES)
    |-> !active[1]) else $error("Pulse pin b overran");
  a_odrain_no_high: assert property (irq_out_a_out |-> $past(irq_cfg[DRIVE_BIT[0]])) else
    $error("Open drain drove high");
  a_level_map: assert property (!irq_out_b_oe_n_out |-> irq_out_b_out
    == ($past(active[1]) == $past(irq_cfg[LEVEL_BIT[1]]))) else $error("Pin b level wrong");
  a_temp_read: assert property (reg_rd_in && reg_addr_in == ADDR_TEMP_HI |=> reg_rdata_out
    == $past(samples.temp[15:8])) else $error("Temperature high byte wrong");
  a_packet_temp: assert property (sample_valid_in ##2 1 |-> temp_packet_byte_out
    == $past(sample_in.temp[15:8], 2)) else $error("Packet temperature wrong");
  a_axis_order: assert property (sample_valid_in ##1 reg_rd_in && reg_addr_in == ADDR_GX_HI && !sample_valid_in
    |=> reg_rdata_out == $past(sample_in.gx[15:8], 2)) else $error("Axis byte order wrong");
  a_stamp_stable: assert property (stamp_held && !sync_tag_read_in |=> $stable(stamp) && stamp_held) else
    $error("Stamp changed while held");
  a_fall_order: assert property (reg_rd_in && reg_addr_in == ADDR_FALL_LO |=> reg_rdata_out
    == $past(fall_dur[7:0])) else $error("Fall low byte wrong");
  a_off_state: assert property (power[GYRO_MODE_LSB +: 2] == 2'h0 && !power[ACCEL_MODE_LSB + 1]
    && !power[IDLE_BIT] |=> cfg_out.chip_off) else $error("Off state missed");
  a_gyro_reserved: assert property (power[GYRO_MODE_LSB +: 2] == MODE_CODE_LOW_POWER |=> cfg_out.gyro == GYRO_OFF)
    else $error("Reserved gyro mode not safe");
  a_avg_frozen: assert property (accel_low_power && wr_afilt |=> $stable(accel_filt[AVG_LSB +: 3])) else
    $error("Averaging changed in low power");
  a_temp_top: assert property (temp_filt[TFILT_LSB +: 3] == 3'h7 |=> cfg_out.temperature_filter_width
    == TFILT_TOP) else $error("Temperature filter top code wrong");
  a_rate_reserved: assert property (rate_cfg[ODR_LSB +: 4] > RATE_CODE_LAST |=> !cfg_out.rate_odr_valid)
    else $error("Reserved gyro rate reported valid");

  c_latched_clear: cover property (active[0] && irq_cfg[LATCH_BIT[0]] ##1 irq_clear_in[0] ##1 !active[0]);
  c_stamp_cycle: cover property (stamp_take ##[1:20] sync_tag_read_in);
  c_gyro_on: cover property (cfg_out.gyro == GYRO_OFF ##1 cfg_out.gyro == GYRO_LOW_NOISE);
  c_pulse_b: cover property (!irq_cfg[LATCH_BIT[1]] && irq_event_in[1] ##1 active[1]);
  c_avg_refused: cover property (accel_low_power && wr_afilt);
endmodule : imu_sensor_config_regs

// ### hdl/imu_cfg_pkg.sv
package imu_cfg_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_IRQ_CFG = 8'h06;
  localparam logic [7:0] ADDR_TEMP_HI = 8'h09;
  localparam logic [7:0] ADDR_TEMP_LO = 8'h0a;
  localparam logic [7:0] ADDR_AX_HI = 8'h0b;
  localparam logic [7:0] ADDR_AX_LO = 8'h0c;
  localparam logic [7:0] ADDR_AY_HI = 8'h0d;
  localparam logic [7:0] ADDR_AY_LO = 8'h0e;
  localparam logic [7:0] ADDR_AZ_HI = 8'h0f;
  localparam logic [7:0] ADDR_AZ_LO = 8'h10;
  localparam logic [7:0] ADDR_GX_HI = 8'h11;
  localparam logic [7:0] ADDR_GX_LO = 8'h12;
  localparam logic [7:0] ADDR_GY_HI = 8'h13;
  localparam logic [7:0] ADDR_GY_LO = 8'h14;
  localparam logic [7:0] ADDR_GZ_HI = 8'h15;
  localparam logic [7:0] ADDR_GZ_LO = 8'h16;
  localparam logic [7:0] ADDR_STAMP_HI = 8'h17;
  localparam logic [7:0] ADDR_STAMP_LO = 8'h18;
  localparam logic [7:0] ADDR_FALL_LO = 8'h1d;
  localparam logic [7:0] ADDR_FALL_HI = 8'h1e;
  localparam logic [7:0] ADDR_POWER = 8'h1f;
  localparam logic [7:0] ADDR_RATE_CFG = 8'h20;
  localparam logic [7:0] ADDR_ACCEL_CFG = 8'h21;
  localparam logic [7:0] ADDR_TEMP_FILT = 8'h22;
  localparam logic [7:0] ADDR_RATE_FILT = 8'h23;
  localparam logic [7:0] ADDR_ACCEL_FILT = 8'h24;
  localparam logic [7:0] ADDR_MOTION = 8'h25;
  // Reset values
  localparam logic [7:0] RST_IRQ_CFG = 8'h00;
  localparam logic [15:0] RST_SAMPLE = 16'h8000;
  localparam logic [7:0] RST_POWER = 8'h80;
  localparam logic [7:0] RST_RATE_CFG = 8'h06;
  localparam logic [7:0] RST_ACCEL_CFG = 8'h06;
  localparam logic [7:0] RST_TEMP_FILT = 8'h00;
  localparam logic [7:0] RST_RATE_FILT = 8'h31;
  localparam logic [7:0] RST_ACCEL_FILT = 8'h31;
  localparam logic [7:0] RST_MOTION = 8'h08;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // Pin config bit positions, index 0 is pin a, 1 is pin b
  localparam int LATCH_BIT [2] = '{2, 5};
  localparam int DRIVE_BIT [2] = '{1, 4};
  localparam int LEVEL_BIT [2] = '{0, 3};
  // Field positions
  localparam int CLK_SEL_BIT = 7;
  localparam int IDLE_BIT = 4;
  localparam int GYRO_MODE_LSB = 2;
  localparam int ACCEL_MODE_LSB = 0;
  localparam int FS_LSB = 5;
  localparam int ODR_LSB = 0;
  localparam int TFILT_LSB = 4;
  localparam int AVG_LSB = 4;
  localparam int FILT_LSB = 0;
  // Field codes
  localparam logic [1:0] GYRO_CODE_STANDBY = 2'h1;
  localparam logic [1:0] MODE_CODE_LOW_POWER = 2'h2;
  localparam logic [1:0] MODE_CODE_LOW_NOISE = 2'h3;
  localparam logic [3:0] ODR_FIRST = 4'h5;
  localparam logic [3:0] RATE_CODE_LAST = 4'hc;
  localparam logic [3:0] ACCEL_CODE_LAST = 4'hf;
  localparam logic [3:0] ACCEL_NOISE_ONLY_LAST = 4'h6;
  localparam logic [3:0] ACCEL_POWER_ONLY_FIRST = 4'hd;
  localparam logic [2:0] FILT_BYPASS = 3'h0;
  localparam logic [2:0] TFILT_TOP = 3'h6;
  localparam logic [2:0] AVG_TOP = 3'h5;
  // Pin pulse timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int IRQ_PULSE_NS = 100;
  localparam int IRQ_PULSE_CYCLES = (IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {GYRO_OFF, GYRO_STANDBY, GYRO_LOW_NOISE} gyro_state_t;
  typedef enum logic [1:0] {ACCEL_OFF, ACCEL_LOW_POWER, ACCEL_LOW_NOISE} accel_state_t;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] ax;
    logic [15:0] ay;
    logic [15:0] az;
    logic [15:0] gx;
    logic [15:0] gy;
    logic [15:0] gz;
  } sample_t;

  typedef struct packed {
    gyro_state_t gyro;
    accel_state_t accel;
    logic rc_osc_on;
    logic chip_off;
    logic lowpower_clock_choice;
    logic [1:0] rate_full_scale;
    logic [3:0] rate_output_rate;
    logic rate_odr_valid;
    logic [1:0] accel_full_scale;
    logic [3:0] accel_output_rate;
    logic accel_rate_valid;
    logic [2:0] temperature_filter_width;
    logic [2:0] rate_filter_width;
    logic [2:0] accel_filter_width;
    logic [2:0] accel_averaging;
    logic temp_lowpass_bypass;
    logic rate_lowpass_bypass;
    logic accel_lowpass_bypass;
  } cfg_t;
endpackage : imu_cfg_pkg

// ### testbench/imu_host_model.sv
`timescale 1ns/100ps
module imu_host_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic rd_out,
  output logic [7:0] wdata_out
);
  import imu_cfg_pkg::*;
  logic [7:0] power_shadow;

  initial begin
    addr_out = 8'h00;
    wdata_out = 8'h00;
    wr_out = 1'b0;
    rd_out = 1'b0;
    power_shadow = RST_POWER;
  end

  // Write strobe for one edge; a sensor waking up blocks further writes for 200 us
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic wake;
    wake = (a == ADDR_POWER) && ((!power_shadow[2] && d[2]) || (!power_shadow[1] && d[1]));
    @(posedge clk_in);
    #1;
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(posedge clk_in);
    #1;
    wr_out = 1'b0;
    // Released lines carry the inverse so a stale value is never mistaken for a live one
    addr_out = ~a;
    wdata_out = ~d;
    if (a == ADDR_POWER) power_shadow = d;
    if (wake) repeat (5000) @(posedge clk_in);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    addr_out = a;
    rd_out = 1'b1;
    @(posedge clk_in);
    #1;
    rd_out = 1'b0;
    addr_out = ~a;
    d = rdata_in;
  endtask : rd
endmodule : imu_host_model

// ### testbench/test_imu_sensor_config_regs.sv
`timescale 1ns/100ps
module test_imu_sensor_config_regs;
  import imu_cfg_pkg::*;
  localparam logic [7:0] RW_ADDR [8] = '{8'h06, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25};
  localparam logic [7:0] RW_RST [8] = '{8'h00, 8'h80, 8'h06, 8'h06, 8'h00, 8'h31, 8'h31, 8'h08};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  wire [7:0] addr, wdata, rdata;
  wire wr, rd;
  wire [1:0] pin, pin_oe_n;
  logic [7:0] v, w, pkt;
  logic sample_valid = 1'b0, sync_pin = 1'b0, tag_read = 1'b0, fall_valid = 1'b0;
  sample_t sample = '0;
  logic [15:0] fall_cnt = 16'h0000, s1;
  logic [1:0] irq_event = 2'h0, irq_clear = 2'h0;
  cfg_t cfg;
  int err_count = 0, cmp_count = 0, cycles = 0;

  imu_host_model host (.clk_in(clk), .rdata_in(rdata), .addr_out(addr), .wr_out(wr), .rd_out(rd),
    .wdata_out(wdata));
  imu_sensor_config_regs #(.PULSE_CYCLES(3)) DUT (.clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .sample_valid_in(sample_valid), .sample_in(sample), .frame_sync_input_in(sync_pin),
    .sync_tag_read_in(tag_read), .fall_valid_in(fall_valid), .fall_duration_count_in(fall_cnt),
    .irq_event_in(irq_event), .irq_clear_in(irq_clear), .irq_out_a_out(pin[0]),
    .irq_out_a_oe_n_out(pin_oe_n[0]), .irq_out_b_out(pin[1]), .irq_out_b_oe_n_out(pin_oe_n[1]),
    .cfg_out(cfg), .temp_packet_byte_out(pkt));

  initial begin
    forever #20 clk = ~clk;
  end

  task automatic finish_test();
    if (err_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : finish_test

  // Hang guard, roughly twice the expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_count++;
      $display("Error at %0t: timeout", $time);
      finish_test();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic pulse(ref logic s);
    @(posedge clk);
    #1;
    s = 1'b1;
    @(posedge clk);
    #1;
    s = 1'b0;
  endtask : pulse

  task automatic wcheck(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
    host.wr(a, d);
    host.rd(a, v);
    check(v, e);
  endtask : wcheck

  task automatic read16(input logic [7:0] a, output logic [15:0] r);
    host.rd(a, v);
    host.rd(a + 8'h01, w);
    r = {v, w};
  endtask : read16

  task automatic pin_check(input int p, input logic act, input logic [2:0] c);
    logic lvl;
    lvl = act ^ !c[0];
    check(pin[p], c[1] ? lvl : 1'b0);
    check(pin_oe_n[p], c[1] ? 1'b0 : lvl);
  endtask : pin_check

  initial begin
    logic [15:0] r;
    logic [7:0] d;
    repeat (10) @(posedge clk);
    #1;
    nrst = 1'b1;
    for (int i = 0; i < 8; i++) begin
      host.rd(RW_ADDR[i], v);
      check(v, RW_RST[i]);
    end
    check(pkt, 8'h80);
    check(cfg.chip_off, 1'b1);
    check(cfg.lowpower_clock_choice, 1'b1);
    host.wr(8'h09, 8'h55);
    host.rd(8'h09, v);
    check(v, 8'h80);
    host.rd(8'h07, v);
    check(v, 8'h00);
    sample = 112'ha1b2_c3d4_e5f6_0718_293a_4b5c_6d7e;
    pulse(sample_valid);
    for (int k = 0; k < 14; k++) begin
      host.rd(8'h09 + k[7:0], v);
      check(v, sample[111 - 8 * k -: 8]);
    end
    check(pkt, 8'ha1);
    fall_cnt = 16'h5a3c;
    pulse(fall_valid);
    read16(8'h1d, r);
    check(r, 16'h3c5a);
    // Stamp must survive a second sync edge until the tag is read
    pulse(sync_pin);
    repeat (20) @(posedge clk);
    pulse(sample_valid);
    read16(8'h17, s1);
    check(s1 == 16'h0000, 1'b0);
    pulse(sync_pin);
    repeat (5) @(posedge clk);
    pulse(sample_valid);
    read16(8'h17, r);
    check(r, s1);
    pulse(tag_read);
    repeat (40) @(posedge clk);
    pulse(sample_valid);
    read16(8'h17, r);
    check(r == s1, 1'b0);
    // Gyro codes run off, reserved, standby, low noise, so the gyro is never switched off once on
    for (int i = 0; i < 16; i++) begin
      d = {~i[0], 2'b00, i[2] ^ i[0], i[2], i[3], i[1:0]};
      host.wr(ADDR_POWER, d);
      @(posedge clk);
      #1;
      check(cfg.gyro, d[3:2] == 2'h1 ? GYRO_STANDBY : d[3:2] == 2'h3 ? GYRO_LOW_NOISE : GYRO_OFF);
      check(cfg.accel, i[1:0] == 2'h2 ? ACCEL_LOW_POWER : i[1:0] == 2'h3 ? ACCEL_LOW_NOISE : ACCEL_OFF);
      check(cfg.chip_off, !d[4] && !d[2] && !d[1]);
      check(cfg.lowpower_clock_choice, d[7]);
    end
    for (int m = 0; m < 2; m++) begin
      host.wr(ADDR_POWER, m ? 8'h8e : 8'h8f);
      for (int i = 0; i < 16; i++) begin
        d = {1'b0, i[1:0], 1'b0, i[3:0]};
        wcheck(ADDR_RATE_CFG, d, d);
        check(cfg.rate_full_scale, i[1:0]);
        check(cfg.rate_output_rate, i[3:0]);
        check(cfg.rate_odr_valid, i >= 5 && i <= 12);
        wcheck(ADDR_ACCEL_CFG, d, d);
        check(cfg.accel_full_scale, i[1:0]);
        check(cfg.accel_output_rate, i[3:0]);
        check(cfg.accel_rate_valid, m ? i >= 7 : i >= 5 && i <= 12);
      end
    end
    // First pass runs in low power, where averaging writes are deliberately attempted
    for (int m = 0; m < 2; m++) begin
      for (int i = 0; i < 8; i++) begin
        d = {1'b0, i[2:0], 1'b0, i[2:0]};
        wcheck(ADDR_TEMP_FILT, {1'b0, i[2:0], 4'h0}, {1'b0, i[2:0], 4'h0});
        check(cfg.temperature_filter_width, i == 7 ? 3'h6 : i[2:0]);
        check(cfg.temp_lowpass_bypass, i == 0);
        wcheck(ADDR_RATE_FILT, {5'h06, i[2:0]}, {5'h06, i[2:0]});
        check(cfg.rate_filter_width, i[2:0]);
        check(cfg.rate_lowpass_bypass, i == 0);
        wcheck(ADDR_ACCEL_FILT, d, m ? d : {4'h3, 1'b0, i[2:0]});
        check(cfg.accel_filter_width, i[2:0]);
        check(cfg.accel_lowpass_bypass, i == 0);
        check(cfg.accel_averaging, m ? (i > 5 ? 3'h5 : i[2:0]) : 3'h3);
      end
      host.wr(ADDR_POWER, 8'h8f);
    end
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 8; c++) begin
        wcheck(ADDR_IRQ_CFG, 8'(c << (3 * p)), 8'(c << (3 * p)));
        pin_check(p, 1'b0, c[2:0]);
        @(posedge clk);
        #1;
        irq_event[p] = 1'b1;
        @(posedge clk);
        #1;
        irq_event[p] = 1'b0;
        repeat (2) @(posedge clk);
        #1;
        pin_check(p, 1'b1, c[2:0]);
        repeat (6) @(posedge clk);
        #1;
        pin_check(p, c[2], c[2:0]);
        irq_clear[p] = 1'b1;
        @(posedge clk);
        #1;
        irq_clear[p] = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        pin_check(p, 1'b0, c[2:0]);
      end
    end
    finish_test();
  end
endmodule : test_imu_sensor_config_regs
